// ==== fcs_sequencer.sv ====
// flash command sequencer: AXI4-Lite registers, command queue, algorithm clock divider
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "fcs_map.svh"
module fcs_sequencer #(
    parameter int ADDR_W = 18
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic special_mode,
    output logic op_start,
    output logic [7:0] op_code,
    output logic [15:0] op_addr,
    output logic [15:0] op_data,
    input wire logic op_done,
    input wire logic op_blank,
    output logic alg_tick,
    output logic irq_buffer_empty,
    output logic irq_complete
);
    import fcs_pkg::*;

    // ****************************************
    // bus write capture
    // ****************************************
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    // address and data may arrive in either order; write happens once both are held
    assign wr_go = aw_full && w_full && !s_axi_bvalid;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_full <= 1'b0;
        end
    end

    function automatic logic idx_mapped(input logic [3:0] idx);
        case (idx)
            `FCS_IDX_DIV, `FCS_IDX_CFG, `FCS_IDX_PROT, `FCS_IDX_STAT,
            `FCS_IDX_CMD, `FCS_IDX_TST_A, `FCS_IDX_ADDR, `FCS_IDX_DATA,
            `FCS_IDX_TST_B, `FCS_IDX_TST_C, `FCS_IDX_TST_D, `FCS_IDX_TST_E: idx_mapped = 1'b1;
            default: idx_mapped = 1'b0;
        endcase
    endfunction

    // array window is the upper half of the address space
    logic w_arr;
    logic w_ok;
    logic w_reg;
    logic [3:0] widx;
    logic [7:0] wlo;
    assign w_arr = aw_addr[ADDR_W-1];
    assign widx = aw_addr[5:2];
    assign w_ok = w_arr || ((aw_addr[ADDR_W-2:6] == '0) && idx_mapped(widx));
    assign w_reg = wr_go && !w_arr;
    assign wlo = w_data[7:0];

    logic wr_arr;
    logic wr_div;
    logic wr_cfg;
    logic wr_prot;
    logic wr_stat;
    logic wr_cmd;
    assign wr_arr = wr_go && w_arr;
    assign wr_div = w_reg && widx == `FCS_IDX_DIV && w_strb[0];
    assign wr_cfg = w_reg && widx == `FCS_IDX_CFG && w_strb[0];
    assign wr_prot = w_reg && widx == `FCS_IDX_PROT && w_strb[0];
    assign wr_stat = w_reg && widx == `FCS_IDX_STAT && w_strb[0];
    assign wr_cmd = w_reg && widx == `FCS_IDX_CMD && w_strb[0];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FCS_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_ok ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    logic [6:0] div_reg;
    logic div_loaded;
    logic [1:0] cfg_reg;
    logic [2:0] prot_reg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            div_reg <= `FCS_RST_DIV;
            div_loaded <= 1'b0;
        end else if (wr_div) begin
            div_reg <= wlo[6:0];
            div_loaded <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cfg_reg <= `FCS_RST_CFG;
            prot_reg <= `FCS_RST_PROT;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= {wlo[`FCS_CFG_BEIE], wlo[`FCS_CFG_COMPLETE_IRQ_ENABLE]};
            end
            if (wr_prot) begin
                prot_reg <= wlo[2:0];
            end
        end
    end

    // ****************************************
    // algorithm clock divider
    // ****************************************
    // period is (divider_value + 1) bus cycles, times eight when prescaled
    logic [2:0] pre_cnt;
    logic [5:0] div_cnt;
    logic pre_tick;
    assign pre_tick = !div_reg[`FCS_DIV_PRE8] || pre_cnt == 3'h7;

    always_ff @(posedge mclk) begin
        if (!resetn || !div_loaded) begin
            pre_cnt <= 3'h0;
            div_cnt <= 6'h00;
            alg_tick <= 1'b0;
        end else begin
            pre_cnt <= pre_cnt + 3'h1;
            alg_tick <= pre_tick && div_cnt == div_reg[5:0];
            if (pre_tick) begin
                div_cnt <= (div_cnt == div_reg[5:0]) ? 6'h00 : div_cnt + 6'h01;
            end
        end
    end

    // ****************************************
    // command write sequence
    // ****************************************
    fcs_seq_t seq;
    fcs_seq_t next_seq;
    logic access_error_flag;
    logic protection_violation_flag;
    logic bempty;
    logic cplt;
    logic blank;
    logic pend_valid;
    logic act_busy;
    logic launch;
    logic acc_set;
    logic pv_set;
    logic lock;
    logic cmd_ok;
    logic word_ok;
    logic [7:0] cmd_in;
    logic [7:0] cmd_reg;
    logic [15:0] addr_reg;
    logic [15:0] data_reg;

    assign lock = access_error_flag || protection_violation_flag;
    assign bempty = !pend_valid;
    assign word_ok = !aw_addr[0] && w_strb[1:0] == 2'b11;
    // ignored bits are dropped before the code is judged
    assign cmd_in = wlo & `FCS_CMD_MASK;
    assign cmd_ok = cmd_in == `FCS_CMD_VERIFY || cmd_in == `FCS_CMD_PROGRAM ||
                    cmd_in == `FCS_CMD_SECTOR || cmd_in == `FCS_CMD_MASS;

    always_comb begin
        next_seq = seq;
        acc_set = 1'b0;
        pv_set = 1'b0;
        launch = 1'b0;
        case (seq)
            SEQ_IDLE: begin
                if (wr_arr) begin
                    if (!div_loaded || !bempty || lock || !word_ok) begin
                        acc_set = 1'b1;
                    end else begin
                        next_seq = SEQ_WORD;
                    end
                end
            end
            SEQ_WORD: begin
                if (wr_cmd && cmd_ok) begin
                    next_seq = SEQ_CMD;
                end else if (wr_go) begin
                    // bad code, second word, early launch or any other write aborts
                    acc_set = 1'b1;
                    next_seq = SEQ_IDLE;
                end
            end
            SEQ_CMD: begin
                if (wr_go) begin
                    next_seq = SEQ_IDLE;
                    if (!wr_stat || !wlo[`FCS_ST_BEMPTY] || !div_loaded) begin
                        acc_set = 1'b1;
                    end else if (cmd_reg == `FCS_CMD_MASS && prot_reg != 3'h7) begin
                        pv_set = 1'b1;
                    end else begin
                        launch = 1'b1;
                    end
                end
            end
            default: begin
                next_seq = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            seq <= SEQ_IDLE;
        end else begin
            seq <= next_seq;
        end
    end

    // new events win over a write-1 clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            access_error_flag <= 1'b0;
            protection_violation_flag <= 1'b0;
        end else begin
            access_error_flag <= acc_set || (access_error_flag && !(wr_stat && wlo[`FCS_ST_ACCESS_ERROR_FLAG]));
            protection_violation_flag <= pv_set || (protection_violation_flag && !(wr_stat && wlo[`FCS_ST_PROTECTION_VIOLATION_FLAG]));
        end
    end

    // ****************************************
    // buffer stage registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cmd_reg <= `FCS_RST_BYTE;
            addr_reg <= `FCS_RST_WORD;
            data_reg <= `FCS_RST_WORD;
        end else begin
            if (seq == SEQ_IDLE && next_seq == SEQ_WORD) begin
                addr_reg <= aw_addr[15:0];
                data_reg <= w_data[15:0];
            end else begin
                if (special_mode && w_reg && widx == `FCS_IDX_ADDR) begin
                    if (w_strb[0]) addr_reg[7:0] <= w_data[7:0];
                    if (w_strb[1]) addr_reg[15:8] <= w_data[15:8];
                end
                if (special_mode && w_reg && widx == `FCS_IDX_DATA) begin
                    if (w_strb[0]) data_reg[7:0] <= w_data[7:0];
                    if (w_strb[1]) data_reg[15:8] <= w_data[15:8];
                end
            end
            if (seq == SEQ_WORD && next_seq == SEQ_CMD) begin
                cmd_reg <= wlo & `FCS_CMD_MASK;
            end
        end
    end

    // ****************************************
    // two-stage queue and completion flags
    // ****************************************
    logic move;
    assign move = pend_valid && !act_busy;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pend_valid <= 1'b0;
            act_busy <= 1'b0;
            op_start <= 1'b0;
            op_code <= `FCS_RST_BYTE;
            op_addr <= `FCS_RST_WORD;
            op_data <= `FCS_RST_WORD;
        end else begin
            op_start <= move;
            if (launch) begin
                pend_valid <= 1'b1;
            end else if (move) begin
                pend_valid <= 1'b0;
            end
            if (move) begin
                act_busy <= 1'b1;
                op_code <= cmd_reg;
                op_data <= data_reg;
                // sector erase drops the in-sector offset
                op_addr <= (cmd_reg == `FCS_CMD_SECTOR) ?
                           (addr_reg & `FCS_SECTOR_MASK) : addr_reg;
            end else if (op_done) begin
                act_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cplt <= 1'b1;
            blank <= 1'b0;
        end else begin
            if (launch) begin
                cplt <= 1'b0;
            end else if (op_done && act_busy && !pend_valid) begin
                cplt <= 1'b1;
            end
            // a verify result landing with a new launch is kept, not lost
            if (op_done && act_busy && op_code == `FCS_CMD_VERIFY && op_blank) begin
                blank <= 1'b1;
            end else if (launch) begin
                blank <= 1'b0;
            end
        end
    end

    assign irq_buffer_empty = bempty && cfg_reg[1];
    assign irq_complete = cplt && cfg_reg[0];

    // ****************************************
    // bus read
    // ****************************************
    logic [3:0] ridx;
    logic r_ok;
    logic [31:0] rmux;
    assign ridx = s_axi_araddr[5:2];
    assign r_ok = s_axi_araddr[ADDR_W-1] ||
                  ((s_axi_araddr[ADDR_W-2:6] == '0) && idx_mapped(ridx));
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rmux = 32'h00000000;
        // array reads and factory test slots return zero
        if (!s_axi_araddr[ADDR_W-1]) begin
            case (ridx)
                `FCS_IDX_DIV: rmux[7:0] = {div_loaded, div_reg};
                `FCS_IDX_CFG: rmux[7:6] = cfg_reg;
                `FCS_IDX_PROT: rmux[2:0] = prot_reg;
                `FCS_IDX_STAT: rmux[7:0] = {bempty, cplt, protection_violation_flag, access_error_flag, 1'b0, blank, 2'b00};
                `FCS_IDX_CMD: rmux[7:0] = cmd_reg & `FCS_CMD_MASK;
                `FCS_IDX_ADDR: rmux[15:0] = special_mode ? addr_reg : 16'h0000;
                `FCS_IDX_DATA: rmux[15:0] = special_mode ? data_reg : 16'h0000;
                default: rmux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FCS_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= r_ok ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== fcs_map.svh ====
// register map, field positions, command codes and reset values of the flash command sequencer
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// register indices; byte address is four times the index
`define FCS_IDX_DIV 4'h0
`define FCS_IDX_CFG 4'h3
`define FCS_IDX_PROT 4'h4
`define FCS_IDX_STAT 4'h5
`define FCS_IDX_CMD 4'h6
`define FCS_IDX_TST_A 4'h7
`define FCS_IDX_ADDR 4'h8
`define FCS_IDX_DATA 4'hA
`define FCS_IDX_TST_B 4'hC
`define FCS_IDX_TST_C 4'hD
`define FCS_IDX_TST_D 4'hE
`define FCS_IDX_TST_E 4'hF

// status bit positions
`define FCS_ST_BEMPTY 7
`define FCS_ST_CPLT 6
`define FCS_ST_PROTECTION_VIOLATION_FLAG 5
`define FCS_ST_ACCESS_ERROR_FLAG 4
`define FCS_ST_BLANK 2

// divider, config and protection bit positions
`define FCS_DIV_LOADED 7
`define FCS_DIV_PRE8 6
`define FCS_CFG_BEIE 7
`define FCS_CFG_COMPLETE_IRQ_ENABLE 6
`define FCS_PROT_LOW 0
`define FCS_PROT_HIGH 1
`define FCS_PROT_OPEN 2

// command codes and writable command bits
`define FCS_CMD_VERIFY 8'h05
`define FCS_CMD_PROGRAM 8'h20
`define FCS_CMD_SECTOR 8'h40
`define FCS_CMD_MASS 8'h41
`define FCS_CMD_MASK 8'h65
`define FCS_SECTOR_MASK 16'hFC00

// reset values
`define FCS_RST_DIV 7'h00
`define FCS_RST_CFG 2'h0
`define FCS_RST_PROT 3'h0
`define FCS_RST_BYTE 8'h00
`define FCS_RST_WORD 16'h0000

// answers on the bus
`define FCS_RESP_OKAY 2'h0
`define FCS_RESP_SLVERR 2'h2

`endif

// ==== fcs_pkg.sv ====
// types shared by the flash command sequencer
package fcs_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WORD,
        SEQ_CMD
    } fcs_seq_t;
endpackage

// ==== fcs_sequencer_monitor.sv ====
// concurrent checks on the flash command sequencer ports
`timescale 1ns/10ps
`default_nettype none
module fcs_sequencer_monitor (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic op_start,
    input wire logic [7:0] op_code,
    input wire logic [15:0] op_addr,
    input wire logic [15:0] op_data,
    input wire logic op_done,
    input wire logic irq_complete
);
    // ****
    // array busy window
    // ****
    logic busy_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busy_q <= 1'h0;
        end else if (op_start) begin
            busy_q <= 1'h1;
        end else if (op_done) begin
            busy_q <= 1'h0;
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    chk_start_pulse: assert property (op_start |=> !op_start)
        else $error("start pulse too long");
    chk_start_idle: assert property (op_start |-> !busy_q)
        else $error("start while array busy");
    chk_op_stable: assert property (busy_q |-> $stable({op_code, op_addr, op_data}))
        else $error("operation fields moved while busy");
    chk_sector_low: assert property (op_start && op_code == 8'h40 |-> op_addr[9:0] == 10'h000)
        else $error("sector address low bits kept");
    chk_code_legal: assert property (op_start |-> op_code inside {8'h05, 8'h20, 8'h40, 8'h41})
        else $error("illegal code executed");
    chk_cplt_busy: assert property (busy_q |-> !irq_complete)
        else $error("complete raised while busy");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'h0)
        else $error("bad write response code");
endmodule
bind fcs_sequencer fcs_sequencer_monitor i_mon (
    .mclk(mclk), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .op_start(op_start),
    .op_code(op_code), .op_addr(op_addr), .op_data(op_data), .op_done(op_done),
    .irq_complete(irq_complete)
);
`default_nettype wire

// ==== fcs_array_model.sv ====
// behavioural flash array answering the sequencer operation port
`timescale 1ns/10ps
`default_nettype none
module fcs_array_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic op_start,
    input wire logic [7:0] op_code,
    input wire logic [15:0] op_addr,
    input wire logic [15:0] op_data,
    input wire logic [7:0] lat,
    output logic op_done,
    output logic op_blank,
    output logic [7:0] n_ops,
    output logic [7:0] seen_code,
    output logic [15:0] seen_addr,
    output logic [15:0] seen_data
);
    logic busy;
    logic erased;
    logic blank_q;
    logic noise;
    logic [7:0] cnt;
    // blank only means something beside op_done, so it wanders elsewhere
    assign op_blank = op_done ? blank_q : noise;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busy <= 1'h0;
            op_done <= 1'h0;
            n_ops <= 8'h00;
            cnt <= 8'h00;
            erased <= 1'h0;
            blank_q <= 1'h0;
            noise <= 1'h0;
        end else begin
            noise <= ~noise;
            op_done <= 1'h0;
            if (op_start) begin
                busy <= 1'h1;
                cnt <= lat;
                n_ops <= n_ops + 8'h01;
                seen_code <= op_code;
                seen_addr <= op_addr;
                seen_data <= op_data;
                // one sector erased leaves the array as a whole unchanged
                if (op_code == 8'h20) erased <= 1'h0;
                if (op_code == 8'h41) erased <= 1'h1;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'h0;
                op_done <= 1'h1;
                blank_q <= erased;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fcs_map.svh"
module testbench;
    localparam logic [17:0] ARR = 18'h20000;
    localparam logic [17:0] DIV = {12'h000, `FCS_IDX_DIV, 2'h0};
    localparam logic [17:0] CFG = {12'h000, `FCS_IDX_CFG, 2'h0};
    localparam logic [17:0] PROT = {12'h000, `FCS_IDX_PROT, 2'h0};
    localparam logic [17:0] STAT = {12'h000, `FCS_IDX_STAT, 2'h0};
    localparam logic [17:0] CMD = {12'h000, `FCS_IDX_CMD, 2'h0};
    localparam logic [17:0] ABUF = {12'h000, `FCS_IDX_ADDR, 2'h0};
    localparam logic [17:0] DBUF = {12'h000, `FCS_IDX_DATA, 2'h0};
    localparam logic [3:0] TST [5] = '{`FCS_IDX_TST_A, `FCS_IDX_TST_B,
        `FCS_IDX_TST_C, `FCS_IDX_TST_D, `FCS_IDX_TST_E};
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic special = 1'h0;
    logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
    logic [31:0] wdata = 32'h0, rdata, rd_v;
    logic [7:0] lat = 8'h02, n0, n_ops, seen_code, op_code;
    logic [15:0] seen_addr, seen_data, op_addr, op_data;
    logic awready, wready, bvalid, arready, rvalid, op_start, op_done, op_blank, irq_be, irq_cc;
    logic tick;
    logic [1:0] bresp, rresp, resp;
    int n_mismatch = 0;
    int samples_checked = 0;
    fcs_sequencer i_dut (
        .mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .special_mode(special), .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
        .op_data(op_data), .op_done(op_done), .op_blank(op_blank), .alg_tick(tick),
        .irq_buffer_empty(irq_be), .irq_complete(irq_cc)
    );
    fcs_array_model i_arr (
        .mclk(mclk), .resetn(resetn), .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
        .op_data(op_data), .lat(lat), .op_done(op_done), .op_blank(op_blank), .n_ops(n_ops),
        .seen_code(seen_code), .seen_addr(seen_addr), .seen_data(seen_data)
    );
    always #5 mclk = ~mclk;
    // ****
    // bus and compare helpers
    // ****
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [17:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rd_v = rdata;
        rready <= 1'h0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [17:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_v, exp);
    endtask
    task automatic seq(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
        wr(ARR | {2'h0, a}, {16'h0000, d});
        wr(CMD, {24'h000000, c});
        wr(STAT, 32'h80);
    endtask
    task automatic wait_cc;
        rd_v = 32'h0;
        while (rd_v[6] !== 1'h1) rd(STAT);
    endtask
    task automatic complete_run;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task t_reset;
        rchk(STAT, 32'hC0);
        rchk(DIV, 32'h00);
        foreach (TST[k]) begin
            wr({12'h000, TST[k], 2'h0}, 32'hFF);
            rchk({12'h000, TST[k], 2'h0}, 32'h00);
        end
        wr(18'h00004, 32'hFF);
        chk(resp, 32'h2);
        chk({irq_be, irq_cc}, 32'h0);
    endtask
    task t_nodiv;
        n0 = n_ops;
        seq(16'h0100, 16'h1111, `FCS_CMD_PROGRAM);
        rchk(STAT, 32'hD0);
        chk(n_ops, n0);
        wr(STAT, 32'h00);
        rchk(STAT, 32'hD0);
        wr(STAT, 32'h10);
        rchk(STAT, 32'hC0);
        // 100 MHz / 8 / 63 is about 198 kHz, inside the allowed band
        wr(DIV, 32'h7E);
        rchk(DIV, 32'hFE);
    endtask
    task t_tick;
        int c;
        do @(posedge mclk); while (!tick);
        c = 0;
        do begin
            @(posedge mclk);
            c++;
        end while (!tick);
        chk(c, 32'h1F8);
    endtask
    task t_prog;
        seq(16'h1234, 16'hBEEF, `FCS_CMD_PROGRAM);
        wait_cc;
        chk({seen_data, seen_addr}, 32'hBEEF1234);
        chk(seen_code, 32'h20);
        rchk(STAT, 32'hC0);
        seq(16'h07FE, 16'h0000, `FCS_CMD_SECTOR);
        wait_cc;
        chk({seen_code, seen_addr}, 32'h400400);
    endtask
    task t_cmd;
        n0 = n_ops;
        wr(ARR | 18'h00300, 32'h5555);
        wr(CMD, 32'hBA);
        rchk(CMD, 32'h20);
        wr(STAT, 32'h80);
        wait_cc;
        chk(seen_code, 32'h20);
        seq(16'h0300, 16'h0000, 8'h25);
        rchk(STAT, 32'hD0);
        chk(n_ops, n0 + 8'h01);
        wr(STAT, 32'h10);
    endtask
    task t_mass;
        seq(16'h0000, 16'h0000, `FCS_CMD_MASS);
        rchk(STAT, 32'hE0);
        wr(STAT, 32'h20);
        rchk(STAT, 32'hC0);
        wr(PROT, 32'h07);
        seq(16'h4000, 16'h0000, `FCS_CMD_MASS);
        wait_cc;
        chk(seen_code, 32'h41);
        seq(16'h0000, 16'h0000, `FCS_CMD_VERIFY);
        wait_cc;
        rchk(STAT, 32'hC4);
        seq(16'h0010, 16'h0001, `FCS_CMD_PROGRAM);
        seq(16'h0000, 16'h0000, `FCS_CMD_VERIFY);
        wait_cc;
        rchk(STAT, 32'hC0);
    endtask
    task t_queue;
        wr(CFG, 32'hC0);
        chk({irq_be, irq_cc}, 32'h3);
        lat <= 8'h28;
        n0 = n_ops;
        seq(16'h0020, 16'h00AA, `FCS_CMD_PROGRAM);
        seq(16'h0022, 16'h00BB, `FCS_CMD_PROGRAM);
        chk({irq_be, irq_cc}, 32'h0);
        wait_cc;
        chk(n_ops, n0 + 8'h02);
        chk({seen_data, seen_addr}, 32'h00BB0022);
        chk({irq_be, irq_cc}, 32'h3);
        lat <= 8'h02;
    endtask
    task t_abort;
        n0 = n_ops;
        wr(ARR | 18'h00040, 32'h0);
        wr(STAT, 32'h00);
        rchk(STAT, 32'hD0);
        seq(16'h0040, 16'h0001, `FCS_CMD_PROGRAM);
        chk(n_ops, n0);
        wr(STAT, 32'h10);
        rchk(STAT, 32'hC0);
        wr(STAT, 32'h00);
        rchk(STAT, 32'hC0);
    endtask
    task t_buf;
        wr(ABUF, 32'h1234);
        rchk(ABUF, 32'h0);
        rchk(DBUF, 32'h0);
        special <= 1'h1;
        wr(ABUF, 32'h1234);
        rchk(ABUF, 32'h1234);
        wr(DBUF, 32'hA5A5);
        rchk(DBUF, 32'hA5A5);
        special <= 1'h0;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'h1;
        t_reset;
        t_nodiv;
        t_tick;
        t_prog;
        t_cmd;
        t_mass;
        t_queue;
        t_abort;
        t_buf;
        complete_run;
    end
    // generous bound: the whole sequence needs a few thousand cycles
    initial begin
        #400000;
        n_mismatch++;
        complete_run;
    end
endmodule
`default_nettype wire
